// *** inc/wdog_pkg.sv ***
/*
 * Package for the locked watchdog timer: register offsets, field positions,
 * reset values, the lock key, timing constants and the bus carrier struct.
 * Assumes a single 100 MHz clock domain and a plain register port.
 */
`default_nettype none
package wdog_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_HZ = 32_768;
    // Nearest whole divide; the tick rate is only approximate anyway
    localparam int unsigned TICK_DIV = (CLK_HZ + TICK_HZ / 2) / TICK_HZ;
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_RELOAD = 12'h000;
    localparam logic [11:0] OFF_COUNT = 12'h004;
    localparam logic [11:0] OFF_CONTROL = 12'h008;
    localparam logic [11:0] OFF_ICLR = 12'h00C;
    localparam logic [11:0] OFF_RAW = 12'h010;
    localparam logic [11:0] OFF_MASKED = 12'h014;
    localparam logic [11:0] OFF_KEY = 12'hC00;
    localparam int IRQ_EN_POS = 0;
    localparam int RST_EN_POS = 1;
    localparam int FLAG_POS = 0;
    localparam logic [31:0] RELOAD_RST = 32'hFFFFFFFF;
    localparam logic [1:0] CONTROL_RST = 2'h0;
    localparam logic [31:0] UNLOCK_KEY = 32'h1ACCE551;
    localparam int RST_PULSE_CYC = 4;

    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;
endpackage
`default_nettype wire

// *** logic/locked_watchdog_timer.sv ***
/*
 * Locked watchdog timer: 32-bit down counter ticking at about 32.768 kHz,
 * interrupt on expiry, reset request on a second unserved expiry, key lock.
 * Assumes synchronous inputs on clk_in and a master that never waits.
 */
`default_nettype none
module locked_watchdog_timer #(
    parameter int unsigned TICK_DIV_P = wdog_pkg::TICK_DIV
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [wdog_pkg::ADDR_W-1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    output logic irq_out,
    output logic sys_reset_out
);
    import wdog_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] reload_value;
    logic [31:0] count;
    logic irq_enable_bit;
    logic reset_output_enable_bit;
    logic raw_irq_flag;
    logic locked;
    logic [31:0] div_cnt;
    logic [2:0] rst_cnt;
    bus_req_s req;

    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    wire unlocked_wr = req.wr && !locked;
    wire wr_reload = unlocked_wr && req.addr == OFF_RELOAD;
    wire wr_control = unlocked_wr && req.addr == OFF_CONTROL;
    wire wr_iclr = unlocked_wr && req.addr == OFF_ICLR;
    wire wr_key = req.wr && req.addr == OFF_KEY;
    wire tick = irq_enable_bit && div_cnt == TICK_DIV_P - 1;
    wire expire = tick && count == 32'h00000000;
    wire enabling = wr_control && req.wdata[IRQ_EN_POS] && !irq_enable_bit;
    wire masked_irq_flag = raw_irq_flag && irq_enable_bit;
    wire fire_reset = expire && raw_irq_flag && reset_output_enable_bit;

    ////////////////////////////////////////////////////////////////////////////
    // Divider runs only while enabled, so each restart gets a full first tick
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            div_cnt <= 32'h00000000;
        end else if (!irq_enable_bit || tick || wr_reload || wr_iclr) begin
            div_cnt <= 32'h00000000;
        end else begin
            div_cnt <= div_cnt + 32'h00000001;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reload_value <= RELOAD_RST;
        end else if (wr_reload) begin
            reload_value <= req.wdata;
        end
    end

    // Reload from the new value on a reload write, else from the stored one
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            count <= RELOAD_RST;
        end else if (wr_reload) begin
            count <= req.wdata;
        end else if (wr_iclr || enabling) begin
            count <= reload_value;
        end else if (expire) begin
            count <= reload_value;
        end else if (tick) begin
            count <= count - 32'h00000001;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_enable_bit <= CONTROL_RST[IRQ_EN_POS];
            reset_output_enable_bit <= CONTROL_RST[RST_EN_POS];
        end else if (wr_control) begin
            irq_enable_bit <= req.wdata[IRQ_EN_POS];
            reset_output_enable_bit <= req.wdata[RST_EN_POS];
        end
    end

    // An expiry in the clearing cycle wins, so no event is lost
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            raw_irq_flag <= 1'b0;
        end else if (expire) begin
            raw_irq_flag <= 1'b1;
        end else if (wr_iclr) begin
            raw_irq_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            locked <= 1'b0;
        end else if (wr_key) begin
            locked <= req.wdata != UNLOCK_KEY;
        end
    end

    // Stretched pulse so slow reset logic still sees it
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_cnt <= 3'h0;
        end else if (fire_reset) begin
            rst_cnt <= 3'(RST_PULSE_CYC);
        end else if (rst_cnt != 3'h0) begin
            rst_cnt <= rst_cnt - 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    logic [31:0] rd_mux;
    always_comb begin
        unique case (req.addr)
            OFF_RELOAD: rd_mux = reload_value;
            OFF_COUNT: rd_mux = count;
            OFF_CONTROL: rd_mux = {30'h0, reset_output_enable_bit, irq_enable_bit};
            OFF_RAW: rd_mux = {31'h0, raw_irq_flag};
            OFF_MASKED: rd_mux = {31'h0, masked_irq_flag};
            OFF_KEY: rd_mux = {31'h0, locked};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_out <= 32'h00000000;
        end else begin
            rdata_out <= req.rd ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            irq_out <= 1'b0;
            sys_reset_out <= 1'b0;
        end else begin
            irq_out <= masked_irq_flag;
            sys_reset_out <= fire_reset || rst_cnt > 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    property p_reload_restart;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_reload |=> count == $past(wdata_in) && reload_value == $past(wdata_in);
    endproperty
    a_reload_restart: assert property (p_reload_restart) else $error("reload restart");

    property p_expire_reload;
        @(posedge clk_in) disable iff (!nrst_in)
        expire && !wr_reload && !wr_iclr |=> count == reload_value && raw_irq_flag;
    endproperty
    a_expire_reload: assert property (p_expire_reload) else $error("expiry reload");

    property p_clear;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_iclr && !expire && !wr_reload |=> !raw_irq_flag && count == reload_value;
    endproperty
    a_clear: assert property (p_clear) else $error("clear");

    property p_second_reset;
        @(posedge clk_in) disable iff (!nrst_in)
        expire && raw_irq_flag && reset_output_enable_bit |=> sys_reset_out [*4];
    endproperty
    a_second_reset: assert property (p_second_reset) else $error("reset pulse");

    property p_no_reset;
        @(posedge clk_in) disable iff (!nrst_in)
        $rose(sys_reset_out) |-> $past(reset_output_enable_bit) && $past(raw_irq_flag);
    endproperty
    a_no_reset: assert property (p_no_reset) else $error("spurious reset");

    property p_hold;
        @(posedge clk_in) disable iff (!nrst_in)
        !irq_enable_bit && !wr_reload && !wr_control && !wr_iclr |=> $stable(count);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved");

    property p_lock;
        @(posedge clk_in) disable iff (!nrst_in)
        locked && wr_in && addr_in == OFF_CONTROL |=> $stable(irq_enable_bit);
    endproperty
    a_lock: assert property (p_lock) else $error("locked write");

    property p_lock_read;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_in && addr_in == OFF_KEY |=> rdata_out == {31'h0, $past(locked)};
    endproperty
    a_lock_read: assert property (p_lock_read) else $error("lock read");

    property p_irq;
        @(posedge clk_in) disable iff (!nrst_in)
        1'b1 |=> irq_out == $past(raw_irq_flag && irq_enable_bit);
    endproperty
    a_irq: assert property (p_irq) else $error("irq out");

    property p_tick_gap;
        @(posedge clk_in) disable iff (!nrst_in)
        tick |=> !tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("tick spacing");

    property p_tick_step;
        @(posedge clk_in) disable iff (!nrst_in)
        tick && count != 32'h00000000 && !wr_reload && !wr_iclr |=> count == $past(count) - 32'h00000001;
    endproperty
    a_tick_step: assert property (p_tick_step) else $error("tick step");

    property p_enable_restart;
        @(posedge clk_in) disable iff (!nrst_in)
        enabling |=> count == reload_value;
    endproperty
    a_enable_restart: assert property (p_enable_restart) else $error("enable restart");

    property p_div_hold;
        @(posedge clk_in) disable iff (!nrst_in)
        !irq_enable_bit |=> div_cnt == 32'h00000000;
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("divider ran");

    property p_flag_hold;
        @(posedge clk_in) disable iff (!nrst_in)
        raw_irq_flag && !wr_iclr |=> raw_irq_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

    property p_flag_source;
        @(posedge clk_in) disable iff (!nrst_in)
        $rose(raw_irq_flag) |-> $past(expire);
    endproperty
    a_flag_source: assert property (p_flag_source) else $error("flag without expiry");

    property p_unlock;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_in && addr_in == OFF_KEY && wdata_in == UNLOCK_KEY |=> !locked;
    endproperty
    a_unlock: assert property (p_unlock) else $error("unlock");

    property p_relock;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_in && addr_in == OFF_KEY && wdata_in != UNLOCK_KEY |=> locked;
    endproperty
    a_relock: assert property (p_relock) else $error("relock");

    property p_lock_keep;
        @(posedge clk_in) disable iff (!nrst_in)
        !wr_key |=> $stable(locked);
    endproperty
    a_lock_keep: assert property (p_lock_keep) else $error("lock moved");

    property p_locked_reload;
        @(posedge clk_in) disable iff (!nrst_in)
        locked && wr_in && addr_in == OFF_RELOAD |=> $stable(reload_value);
    endproperty
    a_locked_reload: assert property (p_locked_reload) else $error("locked reload");

    property p_lock_rst_en;
        @(posedge clk_in) disable iff (!nrst_in)
        locked && wr_in && addr_in == OFF_CONTROL |=> $stable(reset_output_enable_bit);
    endproperty
    a_lock_rst_en: assert property (p_lock_rst_en) else $error("locked reset enable");

    property p_reload_read;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_in && addr_in == OFF_RELOAD |=> rdata_out == $past(reload_value);
    endproperty
    a_reload_read: assert property (p_reload_read) else $error("reload read");

    property p_count_read;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_in && addr_in == OFF_COUNT |=> rdata_out == $past(count);
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read");

    property p_count_write;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_in && addr_in == OFF_COUNT && !tick |=> $stable(count);
    endproperty
    a_count_write: assert property (p_count_write) else $error("count written");

    property p_clear_read;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_in && addr_in == OFF_ICLR |=> rdata_out == 32'h00000000;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("clear read");

    property p_control_read;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_in && addr_in == OFF_CONTROL |=>
            rdata_out == {30'h0, $past(reset_output_enable_bit), $past(irq_enable_bit)};
    endproperty
    a_control_read: assert property (p_control_read) else $error("control read");

    property p_irq_en_write;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_control |=> irq_enable_bit == $past(wdata_in[IRQ_EN_POS]);
    endproperty
    a_irq_en_write: assert property (p_irq_en_write) else $error("irq enable write");

    property p_rst_en_write;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_control |=> reset_output_enable_bit == $past(wdata_in[RST_EN_POS]);
    endproperty
    a_rst_en_write: assert property (p_rst_en_write) else $error("reset enable write");

    property p_reset_gate;
        @(posedge clk_in) disable iff (!nrst_in)
        !reset_output_enable_bit && rst_cnt == 3'h0 |=> !sys_reset_out;
    endproperty
    a_reset_gate: assert property (p_reset_gate) else $error("reset not gated");

    property p_raw_read;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_in && addr_in == OFF_RAW |=> rdata_out == {31'h0, $past(raw_irq_flag)};
    endproperty
    a_raw_read: assert property (p_raw_read) else $error("raw read");

    property p_raw_write;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_in && addr_in == OFF_RAW && !expire |=> $stable(raw_irq_flag);
    endproperty
    a_raw_write: assert property (p_raw_write) else $error("raw written");

    property p_masked_read;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_in && addr_in == OFF_MASKED |=> rdata_out == {31'h0, $past(raw_irq_flag && irq_enable_bit)};
    endproperty
    a_masked_read: assert property (p_masked_read) else $error("masked read");

    property p_masked_write;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_in && addr_in == OFF_MASKED && !expire |=> $stable(raw_irq_flag);
    endproperty
    a_masked_write: assert property (p_masked_write) else $error("masked written");

    property p_pulse_end;
        @(posedge clk_in) disable iff (!nrst_in)
        fire_reset ##1 !fire_reset [*4] |=> !sys_reset_out;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("reset pulse too long");

    c_expire: cover property (@(posedge clk_in) disable iff (!nrst_in) expire);
    c_reset: cover property (@(posedge clk_in) disable iff (!nrst_in) $rose(sys_reset_out));
    c_lock: cover property (@(posedge clk_in) disable iff (!nrst_in) $rose(locked));
    c_clear: cover property (@(posedge clk_in) disable iff (!nrst_in) wr_iclr && raw_irq_flag);
    c_restart: cover property (@(posedge clk_in) disable iff (!nrst_in) enabling);
endmodule
`default_nettype wire

// *** tb/wdog_sys_model.sv ***
/*
 * System reset logic at the far side of the watchdog: measures each reset request.
 * Assumes the request is a registered high level on the watchdog's clock.
 */
`default_nettype none
module wdog_sys_model (
    input wire logic clk_in,
    input wire logic sys_reset_in,
    output logic [7:0] pulse_len_out = 8'h00,
    output logic [7:0] pulse_count_out = 8'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] run = 8'h00;
    ////////////////////////////////////////////////////////////////////////////////
    // Not cleared by the bench reset, so a request that survives it is still seen
    always @(posedge clk_in) begin
        if (sys_reset_in) begin
            run <= run + 8'h01;
        end else if (run != 8'h00) begin
            pulse_len_out <= run;
            pulse_count_out <= pulse_count_out + 8'h01;
            run <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// *** tb/locked_watchdog_timer_tb_top.sv ***
/*
 * Self-checking bench for the locked watchdog: register table rows, then timing cases.
 * Assumes the divider parameter is cut to 10 clocks per tick.
 */
`default_nettype none
module locked_watchdog_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import wdog_pkg::*;
    localparam int DIV = 10;
    typedef struct packed {logic wr; logic [11:0] addr; logic [31:0] data;} row_s;
    // Read rows carry the expected data; reserved bits are written as 0 in these rows
    localparam row_s ROWS [20] = '{
        '{1'b0, OFF_RELOAD, RELOAD_RST}, '{1'b0, OFF_COUNT, RELOAD_RST},
        '{1'b0, OFF_CONTROL, 32'h0}, '{1'b0, OFF_ICLR, 32'h0}, '{1'b0, OFF_RAW, 32'h0},
        '{1'b0, OFF_MASKED, 32'h0}, '{1'b0, OFF_KEY, 32'h0}, '{1'b0, 12'h018, 32'h0},
        '{1'b1, OFF_KEY, 32'h0}, '{1'b0, OFF_KEY, 32'h1}, '{1'b1, OFF_RELOAD, 32'h5},
        '{1'b0, OFF_RELOAD, RELOAD_RST}, '{1'b1, OFF_KEY, UNLOCK_KEY}, '{1'b0, OFF_KEY, 32'h0},
        '{1'b1, OFF_RELOAD, 32'h5}, '{1'b1, OFF_COUNT, 32'h7}, '{1'b0, OFF_COUNT, 32'h5},
        '{1'b1, OFF_RAW, 32'h1}, '{1'b0, OFF_RAW, 32'h0}, '{1'b0, OFF_RELOAD, 32'h5}};
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, irq, sys_rst;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [7:0] plen, pcnt;
    int fails = 0, checks = 0, n;
    ////////////////////////////////////////////////////////////////////////////////
    locked_watchdog_timer #(.TICK_DIV_P(DIV)) i_dut (.clk_in(clk), .nrst_in(nrst),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .irq_out(irq), .sys_reset_out(sys_rst));
    wdog_sys_model i_sys (.clk_in(clk), .sys_reset_in(sys_rst), .pulse_len_out(plen),
        .pulse_count_out(pcnt));
    initial forever #5 clk = ~clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= v; end
        @(posedge clk) wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk) begin rd <= 1'b1; addr <= a; end
        @(posedge clk) rd <= 1'b0;
        #1 v = rdata;
    endtask
    // Bounded wait for irq (sel 0) or reset request (sel 1); n counts cycles
    task automatic wait_hi(input logic sel, input int lim, output int cyc);
        cyc = 0;
        do begin
            @(posedge clk);
            #1 cyc++;
        end while (((sel ? sys_rst : irq) !== 1'b1) && cyc < lim);
        if (cyc >= lim) begin
            fails++;
            $display("CHECK FAILED wait sel %0d expected high seen low", sel);
            final_report();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        foreach (ROWS[i]) begin
            if (ROWS[i].wr) wr_reg(ROWS[i].addr, ROWS[i].data);
            else begin
                rd_reg(ROWS[i].addr, d);
                check("table read", d, ROWS[i].data);
            end
        end
        wr_reg(OFF_CONTROL, 32'h2);
        rd_reg(OFF_COUNT, d);
        check("count held", d, 32'h5);
        wr_reg(OFF_RELOAD, 32'h2);
        wr_reg(OFF_CONTROL, 32'h3);
        wait_hi(1'b0, 80, n);
        // Three ticks to expiry, then flag and irq register stages
        check("irq period", 32'((n >= 3 * DIV - 2) && (n <= 3 * DIV + 6)), 32'h1);
        rd_reg(OFF_RAW, d);
        check("raw set", d, 32'h1);
        rd_reg(OFF_MASKED, d);
        check("masked set", d, 32'h1);
        wr_reg(OFF_CONTROL, 32'h2);
        rd_reg(OFF_MASKED, d);
        check("masked gated", d, 32'h0);
        check("irq gated", 32'(irq), 32'h0);
        rd_reg(OFF_RAW, d);
        check("raw unmasked", d, 32'h1);
        wr_reg(OFF_ICLR, 32'hFFFFFFFF);
        rd_reg(OFF_RAW, d);
        check("raw cleared", d, 32'h0);
        wr_reg(OFF_CONTROL, 32'h3);
        // Let one tick land first, so a clear that failed to reload would show
        repeat (15) @(posedge clk);
        wr_reg(OFF_ICLR, 32'h0);
        rd_reg(OFF_COUNT, d);
        check("clear reloads", d, 32'h2);
        wait_hi(1'b0, 80, n);
        check("no early reset", 32'(pcnt), 32'h0);
        wait_hi(1'b1, 80, n);
        repeat (8) @(posedge clk);
        check("reset pulses", 32'(pcnt), 32'h1);
        check("reset length", 32'(plen), 32'(RST_PULSE_CYC));
        wr_reg(OFF_ICLR, 32'h0);
        repeat (12) @(posedge clk);
        wr_reg(OFF_CONTROL, 32'h2);
        repeat (3 * DIV) @(posedge clk);
        rd_reg(OFF_COUNT, d);
        check("count frozen", d, 32'h1);
        wr_reg(OFF_CONTROL, 32'h1);
        rd_reg(OFF_COUNT, d);
        check("enable restarts", d, 32'h2);
        repeat (12 * DIV) @(posedge clk);
        #1 check("reset disabled", 32'(pcnt), 32'h1);
        check("irq level", 32'(irq), 32'h1);
        @(posedge clk) nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(OFF_RELOAD, d);
        check("reload after reset", d, RELOAD_RST);
        rd_reg(OFF_CONTROL, d);
        check("control after reset", d, 32'h0);
        check("irq after reset", 32'(irq), 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
